/* File: hw/mqp_consts.svh */
`ifndef MQP_CONSTS_SVH
`define MQP_CONSTS_SVH
// register byte offsets
`define MQP_OFS_IFL_HEAD_BUMP  12'h518
`define MQP_OFS_IPL_TAIL_PTR   12'h51c
`define MQP_OFS_IPL_TAIL_BUMP  12'h520
`define MQP_OFS_IPL_HEAD_PTR   12'h524
`define MQP_OFS_OFL_TAIL_PTR   12'h528
`define MQP_OFS_OFL_TAIL_BUMP  12'h52c
`define MQP_OFS_OFL_HEAD_PTR   12'h530
`define MQP_OFS_IFL_TAIL_PTR   12'h540
`define MQP_OFS_IFL_HEAD_PTR   12'h544
`define MQP_OFS_REGION_CFG     12'h548
// field layout
`define MQP_OFF_W              18
`define MQP_BASE_W             12
`define MQP_BASE_LSB           20
`define MQP_BUMP_BIT           0
`define MQP_DEPTH_W            3
`define MQP_STEP               18'h00004
`define MQP_OFF_RESET          18'h00000
`define MQP_BASE_RESET         12'h000
`define MQP_DEPTH_RESET        3'h0
`endif

/* File: hw/mqp_pkg.sv */
package mqp_pkg;
    // one of the six list offsets kept here
    typedef enum logic [2:0]
    {
        MQP_IFL_TAIL = 3'h0,
        MQP_IFL_HEAD = 3'h1,
        MQP_IPL_TAIL = 3'h2,
        MQP_IPL_HEAD = 3'h3,
        MQP_OFL_TAIL = 3'h4,
        MQP_OFL_HEAD = 3'h5
    } mqp_ptr_t;
endpackage

/* File: hw/mqp_ptr.sv */
`timescale 1ns/1ps
`include "mqp_consts.svh"
// one list offset: software load wins over a hardware step
module mqp_ptr
    import mqp_pkg::*;
(
    input  wire logic                   i_clk,
    input  wire logic                   i_rst_n,
    input  wire logic                   i_load,
    input  wire logic [`MQP_OFF_W-1:0]  i_load_val,
    input  wire logic                   i_step,
    input  wire logic [`MQP_DEPTH_W-1:0] i_depth,
    output logic      [`MQP_OFF_W-1:0]  o_off
);
    logic [`MQP_OFF_W-1:0] off;
    logic [`MQP_OFF_W-1:0] next_off;
    logic [`MQP_OFF_W-1:0] wrap_mask;
    logic [`MQP_OFF_W-1:0] sum;

    ////////////////////////////////////////////////////////////////
    // next offset
    always_comb
    begin
        unique case (i_depth)
            3'h0:    wrap_mask = 18'h003fc;
            3'h1:    wrap_mask = 18'h00ffc;
            3'h2:    wrap_mask = 18'h03ffc;
            3'h3:    wrap_mask = 18'h0fffc;
            default: wrap_mask = 18'h3fffc;
        endcase
        sum = off + `MQP_STEP;
        next_off = off;
        if (i_load)
            next_off = {i_load_val[`MQP_OFF_W-1:2], 2'b00};
        else if (i_step)
            next_off = (off & ~wrap_mask) | (sum & wrap_mask);
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            off <= `MQP_OFF_RESET;
        else
            off <= next_off;
    end

    assign o_off = off;

    property p_wrap;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_step && !i_load)
            |=> ((o_off & ~$past(wrap_mask)) == ($past(o_off) & ~$past(wrap_mask)));
    endproperty
    a_wrap: assert property (p_wrap) else $error("step changed bits above depth");

    property p_low_zero;
        @(posedge i_clk) disable iff (!i_rst_n)
        1'b1 |-> (o_off[1:0] == 2'b00);
    endproperty
    a_low_zero: assert property (p_low_zero) else $error("offset low bits nonzero");
endmodule

/* File: hw/mqp_regs.sv */
`timescale 1ns/1ps
`include "mqp_consts.svh"
// How it works
// - bump bit steps inbound free head
// - bump bit steps inbound post tail
// - bump bit steps outbound free tail
// - inbound port write steps post head
// - outbound port write steps free head
// - region base read-only in upper bits
// - 18-bit offset, low two bits zero
// - software seeds heads, hardware then advances
// - primary reset clears offsets, base and depth
// - bump bit sits in lowest byte
// - step wraps within depth-selected bits
// - base mirrored into every pointer
// - inbound port read steps free tail
module mqp_regs
    import mqp_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [11:0] i_reg_addr,
    input  wire logic [31:0] i_reg_wdata,
    input  wire logic        i_in_port_wr,
    input  wire logic        i_in_port_rd,
    input  wire logic        i_out_port_wr,
    output logic      [31:0] o_reg_rdata,
    output logic             o_reg_ack
);
    localparam int NPTR = 6;

    logic [`MQP_BASE_W-1:0]  base;
    logic [`MQP_BASE_W-1:0]  next_base;
    logic [`MQP_DEPTH_W-1:0] depth;
    logic [`MQP_DEPTH_W-1:0] next_depth;
    logic [31:0]             rdata;
    logic [31:0]             next_rdata;
    logic                    ack;
    logic                    next_ack;
    logic [NPTR-1:0]         load;
    logic [NPTR-1:0]         step;
    logic [NPTR-1:0]         bump;
    logic [`MQP_OFF_W-1:0]   off [NPTR];

    ////////////////////////////////////////////////////////////////
    // write decode per pointer
    always_comb
    begin
        load = '0;
        bump = '0;
        if (i_reg_wr)
        begin
            unique case (i_reg_addr)
                `MQP_OFS_IFL_TAIL_PTR: load[MQP_IFL_TAIL] = 1'b1;
                `MQP_OFS_IFL_HEAD_PTR: load[MQP_IFL_HEAD] = 1'b1;
                `MQP_OFS_IPL_TAIL_PTR: load[MQP_IPL_TAIL] = 1'b1;
                `MQP_OFS_IPL_HEAD_PTR: load[MQP_IPL_HEAD] = 1'b1;
                `MQP_OFS_OFL_TAIL_PTR: load[MQP_OFL_TAIL] = 1'b1;
                `MQP_OFS_OFL_HEAD_PTR: load[MQP_OFL_HEAD] = 1'b1;
                `MQP_OFS_IFL_HEAD_BUMP:
                    bump[MQP_IFL_HEAD] = i_reg_wdata[`MQP_BUMP_BIT];
                `MQP_OFS_IPL_TAIL_BUMP:
                    bump[MQP_IPL_TAIL] = i_reg_wdata[`MQP_BUMP_BIT];
                `MQP_OFS_OFL_TAIL_BUMP:
                    bump[MQP_OFL_TAIL] = i_reg_wdata[`MQP_BUMP_BIT];
                default: ;
            endcase
        end
        // bump is a strobe, no storage
        step = bump;
        step[MQP_IFL_TAIL] = i_in_port_rd;
        step[MQP_IPL_HEAD] = i_in_port_wr;
        step[MQP_OFL_HEAD] = i_out_port_wr;
    end

    ////////////////////////////////////////////////////////////////
    // one offset register per list pointer
    // hardware advance after software seed
    for (genvar g = 0; g < NPTR; g++)
    begin : g_ptr
        mqp_ptr u_ptr
        (
            .i_clk      (i_clk),
            .i_rst_n    (i_rst_n),
            .i_load     (load[g]),
            .i_load_val (i_reg_wdata[`MQP_OFF_W-1:0]),
            .i_step     (step[g]),
            .i_depth    (depth),
            .o_off      (off[g])
        );
    end

    ////////////////////////////////////////////////////////////////
    // region config and read path
    always_comb
    begin
        next_base  = base;
        next_depth = depth;
        if (i_reg_wr && i_reg_addr == `MQP_OFS_REGION_CFG)
        begin
            next_base  = i_reg_wdata[`MQP_BASE_LSB +: `MQP_BASE_W];
            next_depth = i_reg_wdata[`MQP_DEPTH_W-1:0];
        end
        next_ack   = i_reg_wr | i_reg_rd;
        next_rdata = 32'h00000000;
        if (i_reg_rd)
        begin
            unique case (i_reg_addr)
                `MQP_OFS_IFL_TAIL_PTR:
                    next_rdata = {base, 2'b00, off[MQP_IFL_TAIL]};
                `MQP_OFS_IFL_HEAD_PTR:
                    next_rdata = {base, 2'b00, off[MQP_IFL_HEAD]};
                `MQP_OFS_IPL_TAIL_PTR:
                    next_rdata = {base, 2'b00, off[MQP_IPL_TAIL]};
                `MQP_OFS_IPL_HEAD_PTR:
                    next_rdata = {base, 2'b00, off[MQP_IPL_HEAD]};
                `MQP_OFS_OFL_TAIL_PTR:
                    next_rdata = {base, 2'b00, off[MQP_OFL_TAIL]};
                `MQP_OFS_OFL_HEAD_PTR:
                    next_rdata = {base, 2'b00, off[MQP_OFL_HEAD]};
                `MQP_OFS_REGION_CFG:
                    next_rdata = {base, 17'h00000, depth};
                // bump registers and unmapped read zero
                default: next_rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            base  <= `MQP_BASE_RESET;
            depth <= `MQP_DEPTH_RESET;
            rdata <= 32'h00000000;
            ack   <= 1'b0;
        end
        else
        begin
            base  <= next_base;
            depth <= next_depth;
            rdata <= next_rdata;
            ack   <= next_ack;
        end
    end

    assign o_reg_rdata = rdata;
    assign o_reg_ack   = ack;

    ////////////////////////////////////////////////////////////////
    // checks
    property p_in_wr;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_in_port_wr && !load[MQP_IPL_HEAD])
            |=> off[MQP_IPL_HEAD][9:0] == $past(off[MQP_IPL_HEAD][9:0]) + 10'h004
                && ($past(depth) != 3'h4
                    || off[MQP_IPL_HEAD] == $past(off[MQP_IPL_HEAD]) + 18'h00004);
    endproperty
    a_in_wr: assert property (p_in_wr) else $error("post head not stepped");

    property p_out_wr;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_out_port_wr && !load[MQP_OFL_HEAD])
            |=> off[MQP_OFL_HEAD][9:0] == $past(off[MQP_OFL_HEAD][9:0]) + 10'h004
                && ($past(depth) != 3'h4
                    || off[MQP_OFL_HEAD] == $past(off[MQP_OFL_HEAD]) + 18'h00004);
    endproperty
    a_out_wr: assert property (p_out_wr) else $error("free head not stepped");

    property p_in_rd;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_in_port_rd && !load[MQP_IFL_TAIL])
            |=> off[MQP_IFL_TAIL][9:0] == $past(off[MQP_IFL_TAIL][9:0]) + 10'h004
                && ($past(depth) != 3'h4
                    || off[MQP_IFL_TAIL] == $past(off[MQP_IFL_TAIL]) + 18'h00004);
    endproperty
    a_in_rd: assert property (p_in_rd) else $error("free tail not stepped");

    property p_bump1;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_reg_wr && i_reg_addr == `MQP_OFS_IFL_HEAD_BUMP && i_reg_wdata[0])
            |=> off[MQP_IFL_HEAD][9:0] == $past(off[MQP_IFL_HEAD][9:0]) + 10'h004
                && ($past(depth) != 3'h4
                    || off[MQP_IFL_HEAD] == $past(off[MQP_IFL_HEAD]) + 18'h00004);
    endproperty
    a_bump1: assert property (p_bump1) else $error("free head bump lost");

    property p_bump2;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_reg_wr && i_reg_addr == `MQP_OFS_IPL_TAIL_BUMP && i_reg_wdata[0])
            |=> off[MQP_IPL_TAIL][9:0] == $past(off[MQP_IPL_TAIL][9:0]) + 10'h004
                && ($past(depth) != 3'h4
                    || off[MQP_IPL_TAIL] == $past(off[MQP_IPL_TAIL]) + 18'h00004);
    endproperty
    a_bump2: assert property (p_bump2) else $error("post tail bump lost");

    property p_bump3;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_reg_wr && i_reg_addr == `MQP_OFS_OFL_TAIL_BUMP && i_reg_wdata[0])
            |=> off[MQP_OFL_TAIL][9:0] == $past(off[MQP_OFL_TAIL][9:0]) + 10'h004
                && ($past(depth) != 3'h4
                    || off[MQP_OFL_TAIL] == $past(off[MQP_OFL_TAIL]) + 18'h00004);
    endproperty
    a_bump3: assert property (p_bump3) else $error("free tail bump lost");

    property p_bump_zero;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_reg_rd && i_reg_addr == `MQP_OFS_OFL_TAIL_BUMP) |=> o_reg_rdata == 32'h0;
    endproperty
    a_bump_zero: assert property (p_bump_zero) else $error("bump reads nonzero");

    property p_sw_wins;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_reg_wr && i_reg_addr == `MQP_OFS_IPL_HEAD_PTR && i_in_port_wr)
            |=> off[MQP_IPL_HEAD] == {$past(i_reg_wdata[17:2]), 2'b00};
    endproperty
    a_sw_wins: assert property (p_sw_wins) else $error("write lost to step");

    property p_base_ro;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_reg_rd && i_reg_addr == `MQP_OFS_IPL_HEAD_PTR)
            |=> o_reg_rdata[31:20] == $past(base);
    endproperty
    a_base_ro: assert property (p_base_ro) else $error("base not mirrored");

    property p_reset;
        @(posedge i_clk)
        !i_rst_n |=> (off[MQP_OFL_HEAD] == 18'h0 && base == 12'h0);
    endproperty
    a_reset: assert property (p_reset) else $error("reset left state");

    ////////////////////////////////////////////////////////////////
    // more checks: loads, read-back layout, bump strobes
    property p_sw_wins_out;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_reg_wr && i_reg_addr == `MQP_OFS_OFL_HEAD_PTR && i_out_port_wr)
            |=> off[MQP_OFL_HEAD] == {$past(i_reg_wdata[17:2]), 2'b00};
    endproperty
    a_sw_wins_out: assert property (p_sw_wins_out) else $error("write lost to step");

    property p_tail_load;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_reg_wr && i_reg_addr == `MQP_OFS_IPL_TAIL_PTR)
            |=> off[MQP_IPL_TAIL] == {$past(i_reg_wdata[17:2]), 2'b00};
    endproperty
    a_tail_load: assert property (p_tail_load) else $error("tail load wrong");

    property p_gap_zero;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_reg_rd && i_reg_addr == `MQP_OFS_IPL_HEAD_PTR)
            |=> (o_reg_rdata[19:18] == 2'b00 && o_reg_rdata[1:0] == 2'b00);
    endproperty
    a_gap_zero: assert property (p_gap_zero) else $error("spare bits nonzero");

    property p_base_keep;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_reg_wr && i_reg_addr == `MQP_OFS_IPL_HEAD_PTR)
            |=> base == $past(base);
    endproperty
    a_base_keep: assert property (p_base_keep) else $error("pointer write moved base");

    property p_tail_mirror;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_reg_rd && i_reg_addr == `MQP_OFS_IPL_TAIL_PTR)
            |=> o_reg_rdata[31:20] == $past(base);
    endproperty
    a_tail_mirror: assert property (p_tail_mirror) else $error("base not in tail");

    property p_cfg_write;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_reg_wr && i_reg_addr == `MQP_OFS_REGION_CFG)
            |=> (base == $past(i_reg_wdata[31:20]) && depth == $past(i_reg_wdata[2:0]));
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

    property p_bump_noop;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_reg_wr && i_reg_addr == `MQP_OFS_IPL_TAIL_BUMP && !i_reg_wdata[0])
            |=> off[MQP_IPL_TAIL] == $past(off[MQP_IPL_TAIL]);
    endproperty
    a_bump_noop: assert property (p_bump_noop) else $error("zero bump moved tail");

    property p_bump_zero_in;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_reg_rd && i_reg_addr == `MQP_OFS_IPL_TAIL_BUMP) |=> o_reg_rdata == 32'h0;
    endproperty
    a_bump_zero_in: assert property (p_bump_zero_in) else $error("bump reads nonzero");

    property p_bump_zero_ifl;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_reg_rd && i_reg_addr == `MQP_OFS_IFL_HEAD_BUMP) |=> o_reg_rdata == 32'h0;
    endproperty
    a_bump_zero_ifl: assert property (p_bump_zero_ifl) else $error("bump reads nonzero");

    // bus outputs quiet while reset is low
    property p_reset_bus;
        @(posedge i_clk)
        !i_rst_n |=> (!o_reg_ack && o_reg_rdata == 32'h0 && depth == 3'h0);
    endproperty
    a_reset_bus: assert property (p_reset_bus) else $error("reset left bus state");
endmodule

/* File: verification/mqp_host.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// far-side stand-in: the pci host strobing the queue ports
module mqp_host
(
    input  wire logic i_clk,
    output logic      o_in_port_wr,
    output logic      o_in_port_rd,
    output logic      o_out_port_wr
);
    // idle between accesses, so no step is ever seen twice
    initial
    begin
        o_in_port_wr  = 1'b0;
        o_in_port_rd  = 1'b0;
        o_out_port_wr = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one queue access per call; kind is {out write, in read, in write}
    // strobe lasts exactly one edge, a longer one would count twice
    task automatic pulse(input logic [2:0] kind);
        @(posedge i_clk);
        {o_out_port_wr, o_in_port_rd, o_in_port_wr} <= kind;
        @(posedge i_clk);
        {o_out_port_wr, o_in_port_rd, o_in_port_wr} <= 3'h0;
    endtask
endmodule

/* File: verification/message_queue_pointer_regs_tb_top.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// register-level bench for the queue pointer block
module message_queue_pointer_regs_tb_top;
    logic        i_clk;
    logic        i_rst_n;
    logic        i_reg_wr;
    logic        i_reg_rd;
    logic [11:0] i_reg_addr;
    logic [31:0] i_reg_wdata;
    logic        in_wr;
    logic        in_rd;
    logic        out_wr;
    logic [31:0] o_reg_rdata;
    logic        o_reg_ack;
    int          num_errors;
    int          n_checks;
    int          m;
    logic [17:0] v;
    logic [17:0] hi;
    logic [11:0] regs [10] = '{12'h518, 12'h51c, 12'h520, 12'h524, 12'h528,
                               12'h52c, 12'h530, 12'h540, 12'h544, 12'h548};

    mqp_regs dut
    (
        .i_clk        (i_clk),
        .i_rst_n      (i_rst_n),
        .i_reg_wr     (i_reg_wr),
        .i_reg_rd     (i_reg_rd),
        .i_reg_addr   (i_reg_addr),
        .i_reg_wdata  (i_reg_wdata),
        .i_in_port_wr (in_wr),
        .i_in_port_rd (in_rd),
        .i_out_port_wr(out_wr),
        .o_reg_rdata  (o_reg_rdata),
        .o_reg_ack    (o_reg_ack)
    );

    mqp_host host
    (
        .i_clk        (i_clk),
        .o_in_port_wr (in_wr),
        .o_in_port_rd (in_rd),
        .o_out_port_wr(out_wr)
    );

    always #25 i_clk = ~i_clk;

    ////////////////////////////////////////////////////////////////////////////
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // one-cycle strobe; ack and data are looked at in the single cycle they stand
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_reg_wr    <= w;
        i_reg_rd    <= ~w;
        i_reg_addr  <= a;
        i_reg_wdata <= d;
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
        i_reg_rd <= 1'b0;
        #1;
        chk({31'h0, o_reg_ack}, 32'h1);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk(o_reg_rdata, e);
    endtask

    task automatic results;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // hang guard, far beyond the 147 cycles the tests need
    initial
    begin
        #1000000;
        num_errors++;
        results();
    end

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        i_clk       = 1'b0;
        i_rst_n     = 1'b0;
        i_reg_wr    = 1'b0;
        i_reg_rd    = 1'b0;
        i_reg_addr  = 12'h000;
        i_reg_wdata = 32'h0;
        repeat (16) @(posedge i_clk);
        i_rst_n <= 1'b1;
        foreach (regs[k]) rd(regs[k], 32'h0);
        // base 0xabc, depth code 0; pointer write also hits base and low bits
        acc(1'b1, 12'h548, 32'habc00000);
        acc(1'b1, 12'h524, 32'h123103ff);
        rd(12'h524, 32'habc103fc);
        // software equalises the inbound post list before use
        acc(1'b1, 12'h51c, 32'h000103fc);
        rd(12'h51c, 32'habc103fc);
        host.pulse(3'h1);
        rd(12'h524, 32'habc10000);
        acc(1'b1, 12'h520, 32'hfffffffe);
        rd(12'h520, 32'h0);
        rd(12'h51c, 32'habc103fc);
        acc(1'b1, 12'h520, 32'h1);
        rd(12'h51c, 32'habc10000);
        // outbound free list made empty, then both ends moved
        acc(1'b1, 12'h530, 32'h40);
        acc(1'b1, 12'h528, 32'h40);
        host.pulse(3'h4);
        rd(12'h530, 32'habc00044);
        acc(1'b1, 12'h52c, 32'h1);
        rd(12'h528, 32'habc00044);
        host.pulse(3'h2);
        rd(12'h540, 32'habc00004);
        acc(1'b1, 12'h518, 32'h1);
        rd(12'h544, 32'habc00004);
        // port step and pointer write on the same edge
        fork
            host.pulse(3'h4);
            acc(1'b1, 12'h530, 32'h200);
        join
        rd(12'h530, 32'habc00200);
        fork
            host.pulse(3'h1);
            acc(1'b1, 12'h524, 32'h100);
        join
        rd(12'h524, 32'habc00100);
        rd(12'h600, 32'h0);
        // depth codes 0 to 5: top of each range wraps, bits above are kept
        for (int d = 0; d < 6; d++)
        begin
            m = (d > 4) ? 17 : 9 + 2 * d;
            hi = (m < 17) ? 18'h20000 : 18'h0;
            v = 18'((1 << (m + 1)) - 4) | hi;
            acc(1'b1, 12'h548, 32'(d));
            acc(1'b1, 12'h51c, {14'h0, v});
            acc(1'b1, 12'h520, 32'h1);
            rd(12'h51c, {14'h0, hi});
        end
        // second reset in mid-run clears offsets and config
        // nonzero base first, so the cleared read means something
        acc(1'b1, 12'h548, 32'hfff00004);
        @(posedge i_clk);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rd(12'h530, 32'h0);
        rd(12'h548, 32'h0);
        results();
    end
endmodule
